// *** rtl/ssr_pkg.sv ***
// Shared constants for the soft-stop timing register block.
// Assumes a 100 MHz ref_clk and a command-level PMBus engine in front.
package ssr_pkg;

    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
    localparam logic [7:0] CMD_SOFT_STOP_RAMP = 8'h65;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam logic [4:0] EXP_VALUE = 5'h1F;
    localparam int DELAY_MANT_W = 3;
    localparam int RAMP_MANT_W = 4;
    localparam logic [2:0] DELAY_MANT_RESET = 3'h0;
    localparam logic [3:0] RAMP_MANT_RESET = 4'h0;

    // ****************************************************************
    // Canonical restore mantissas, one per supported setting
    // ****************************************************************
    localparam logic [2:0] DELAY_CANON_0MS = 3'h0;
    localparam logic [2:0] DELAY_CANON_1MS = 3'h1;
    localparam logic [2:0] DELAY_CANON_1P5MS = 3'h3;
    localparam logic [2:0] DELAY_CANON_2MS = 3'h4;
    localparam logic [3:0] RAMP_CANON_0P5MS = 4'h0;
    localparam logic [3:0] RAMP_CANON_1MS = 4'h2;
    localparam logic [3:0] RAMP_CANON_2MS = 4'h4;
    localparam logic [3:0] RAMP_CANON_4MS = 4'h8;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_US_NS = 1000;
    localparam int US_CYCLES = TICK_US_NS / CLK_PERIOD_NS;
    localparam int HALF_MS_US = 500;
    // Base ramp of 0.5 ms is about 2^9 microsecond steps
    localparam int RAMP_BASE_SHIFT = 9;
    // Reference code per boot level: (level + 1) << BOOT_CODE_SHIFT
    localparam int BOOT_CODE_SHIFT = 7;
    localparam int REF_W = 16;

endpackage : ssr_pkg

// *** rtl/ssr_tick_gen.sv ***
// Microsecond and half-millisecond tick generator for the stop timers.
// Assumes clr is a same-clock pulse that restarts both counts at zero.
`timescale 1ns/1ns
module ssr_tick_gen #(
    parameter int US_CYCLES = ssr_pkg::US_CYCLES,
    parameter int HALF_MS_US = ssr_pkg::HALF_MS_US
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clr,
    output logic tick_us,
    output logic tick_half_ms
);

    logic [15:0] cyc_cnt;
    logic [15:0] us_cnt;

    // ****************************************************************
    // Cycle divider
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst || clr)
        begin
            cyc_cnt <= 16'h0000;
            tick_us <= 1'b0;
        end
        else if (cyc_cnt == 16'(US_CYCLES - 1))
        begin
            cyc_cnt <= 16'h0000;
            tick_us <= 1'b1;
        end
        else
        begin
            cyc_cnt <= cyc_cnt + 16'h0001;
            tick_us <= 1'b0;
        end
    end

    // ****************************************************************
    // Microsecond divider
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst || clr)
        begin
            us_cnt <= 16'h0000;
            tick_half_ms <= 1'b0;
        end
        else if (tick_us && us_cnt == 16'(HALF_MS_US - 1))
        begin
            us_cnt <= 16'h0000;
            tick_half_ms <= 1'b1;
        end
        else
        begin
            if (tick_us)
            begin
                us_cnt <= us_cnt + 16'h0001;
            end
            tick_half_ms <= 1'b0;
        end
    end

endmodule : ssr_tick_gen

// *** rtl/ssr_soft_stop.sv ***
// Turn-off delay and soft-stop ramp setting registers with the stop
// sequencer that applies them to the reference DAC.
// Assumes a same-clock PMBus command engine, same-clock on/off logic and
// status registers that take the fault pulses; the comparator is async.
`timescale 1ns/1ns
module ssr_soft_stop #(
    parameter int US_CYCLES = ssr_pkg::US_CYCLES,
    parameter int HALF_MS_US = ssr_pkg::HALF_MS_US
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_hit,
    output logic resp_valid,
    output logic resp_nack,
    output logic [15:0] resp_rdata,
    output logic cml_fault_set,
    output logic invalid_data_set,
    input wire logic nvm_restore,
    input wire logic [1:0] nvm_delay_sel,
    input wire logic [1:0] nvm_ramp_sel,
    input wire logic stop_req,
    input wire logic [4:0] boot_voltage_level,
    input wire logic vout_low_pin,
    output logic switching_en,
    output logic ramp_active,
    output logic [15:0] ref_dac_code
);

    // ****************************************************************
    // Types and mapping functions
    // ****************************************************************
    typedef enum logic [3:0] {
        SSR_IDLE = 4'b0001,
        SSR_DELAY = 4'b0010,
        SSR_RAMP = 4'b0100,
        SSR_OFF = 4'b1000
    } ssr_state_t;

    // Delay in half-millisecond units
    function automatic logic [2:0] ssr_delay_halves(input logic [2:0] m);
        if (m == 3'h0)
        begin
            return 3'h0;
        end
        else if (m < 3'h3)
        begin
            return 3'h2;
        end
        else if (m == 3'h3)
        begin
            return 3'h3;
        end
        else
        begin
            return 3'h4;
        end
    endfunction : ssr_delay_halves

    // Ramp length as a power of two over the 0.5 ms base
    function automatic logic [1:0] ssr_ramp_shift(input logic [3:0] m);
        if (m < 4'h2)
        begin
            return 2'h0;
        end
        else if (m < 4'h4)
        begin
            return 2'h1;
        end
        else if (m < 4'h8)
        begin
            return 2'h2;
        end
        else
        begin
            return 2'h3;
        end
    endfunction : ssr_ramp_shift

    function automatic logic [15:0] ssr_word(input logic [3:0] m);
        return {ssr_pkg::EXP_VALUE, 7'h00, m};
    endfunction : ssr_word

    // ****************************************************************
    // Signals
    // ****************************************************************
    ssr_state_t state;
    ssr_state_t next_state;
    logic [2:0] delay_mant;
    logic [3:0] ramp_mant;
    logic is_delay;
    logic is_ramp;
    logic wr_ok;
    logic [2:0] delay_left;
    logic [1:0] ramp_shift_run;
    logic [15:0] ramp_step;
    logic [15:0] ref_start;
    logic tick_clr;
    logic tick_us;
    logic tick_half_ms;
    logic vout_s1;
    logic vout_s2;
    logic vout_s3;
    logic vout_low;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    always_comb
    begin
        is_delay = 1'b0;
        is_ramp = 1'b0;
        if (cmd_code == ssr_pkg::CMD_TURN_OFF_DELAY)
        begin
            is_delay = 1'b1;
        end
        else if (cmd_code == ssr_pkg::CMD_SOFT_STOP_RAMP)
        begin
            is_ramp = 1'b1;
        end
    end

    assign cmd_hit = cmd_valid && (is_delay || is_ramp);

    // Write legal only if every read-only bit keeps its read value
    always_comb
    begin
        wr_ok = 1'b0;
        if (is_delay)
        begin
            wr_ok = cmd_wdata[15:3] == {ssr_pkg::EXP_VALUE, 8'h00};
        end
        else if (is_ramp)
        begin
            wr_ok = cmd_wdata[15:4] == {ssr_pkg::EXP_VALUE, 7'h00};
        end
    end

    // ****************************************************************
    // Setting registers
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            delay_mant <= ssr_pkg::DELAY_MANT_RESET;
        end
        else if (nvm_restore)
        begin
            case (nvm_delay_sel)
                2'h0: delay_mant <= ssr_pkg::DELAY_CANON_0MS;
                2'h1: delay_mant <= ssr_pkg::DELAY_CANON_1MS;
                2'h2: delay_mant <= ssr_pkg::DELAY_CANON_1P5MS;
                default: delay_mant <= ssr_pkg::DELAY_CANON_2MS;
            endcase
        end
        else if (cmd_valid && cmd_write && is_delay && wr_ok)
        begin
            delay_mant <= cmd_wdata[2:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ramp_mant <= ssr_pkg::RAMP_MANT_RESET;
        end
        else if (nvm_restore)
        begin
            case (nvm_ramp_sel)
                2'h0: ramp_mant <= ssr_pkg::RAMP_CANON_0P5MS;
                2'h1: ramp_mant <= ssr_pkg::RAMP_CANON_1MS;
                2'h2: ramp_mant <= ssr_pkg::RAMP_CANON_2MS;
                default: ramp_mant <= ssr_pkg::RAMP_CANON_4MS;
            endcase
        end
        else if (cmd_valid && cmd_write && is_ramp && wr_ok)
        begin
            ramp_mant <= cmd_wdata[3:0];
        end
    end

    // ****************************************************************
    // Response and fault pulses
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            resp_valid <= 1'b0;
            resp_nack <= 1'b0;
            resp_rdata <= 16'h0000;
            cml_fault_set <= 1'b0;
            invalid_data_set <= 1'b0;
        end
        else
        begin
            resp_valid <= cmd_hit;
            resp_nack <= cmd_hit && cmd_write && !wr_ok;
            cml_fault_set <= cmd_hit && cmd_write && !wr_ok;
            invalid_data_set <= cmd_hit && cmd_write && !wr_ok;
            if (cmd_hit && !cmd_write && is_delay)
            begin
                resp_rdata <= ssr_word({1'b0, delay_mant});
            end
            else if (cmd_hit && !cmd_write)
            begin
                resp_rdata <= ssr_word(ramp_mant);
            end
            else
            begin
                resp_rdata <= 16'h0000;
            end
        end
    end

    // ****************************************************************
    // Output-low comparator synchroniser
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            vout_s1 <= 1'b0;
            vout_s2 <= 1'b0;
            vout_s3 <= 1'b0;
            vout_low <= 1'b0;
        end
        else
        begin
            vout_s1 <= vout_low_pin;
            vout_s2 <= vout_s1;
            vout_s3 <= vout_s2;
            if (vout_s2 == vout_s3)
            begin
                vout_low <= vout_s3;
            end
        end
    end

    // ****************************************************************
    // Timebase
    // ****************************************************************
    // Restarted at the stop edge so the first half-ms is a whole one
    assign tick_clr = (state == SSR_IDLE) && stop_req;

    ssr_tick_gen #(
        .US_CYCLES(US_CYCLES),
        .HALF_MS_US(HALF_MS_US)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .clr(tick_clr),
        .tick_us(tick_us),
        .tick_half_ms(tick_half_ms)
    );

    // ****************************************************************
    // Stop sequencer
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        case (state)
            SSR_IDLE:
            begin
                if (stop_req)
                begin
                    next_state = SSR_DELAY;
                end
            end
            SSR_DELAY:
            begin
                if (delay_left == 3'h0)
                begin
                    next_state = SSR_RAMP;
                end
            end
            SSR_RAMP:
            begin
                if (ref_dac_code == 16'h0000)
                begin
                    next_state = SSR_OFF;
                end
            end
            SSR_OFF:
            begin
                if (!stop_req)
                begin
                    next_state = SSR_IDLE;
                end
            end
            default:
            begin
                next_state = SSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state <= SSR_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Settings are sampled once per stop; later writes wait for the next
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            delay_left <= 3'h0;
            ramp_shift_run <= 2'h0;
        end
        else if (tick_clr)
        begin
            delay_left <= ssr_delay_halves(delay_mant);
            ramp_shift_run <= ssr_ramp_shift(ramp_mant);
        end
        else if (state == SSR_DELAY && tick_half_ms && delay_left != 3'h0)
        begin
            delay_left <= delay_left - 3'h1;
        end
    end

    // Start code per boot level; step sized so 0.5 ms ~ 512 us steps
    assign ref_start = 16'({11'h000, boot_voltage_level} + 16'h0001)
        << ssr_pkg::BOOT_CODE_SHIFT;

    // ****************************************************************
    // Reference ramp
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ref_dac_code <= 16'h0000;
            ramp_step <= 16'h0000;
        end
        else if (state == SSR_DELAY && next_state == SSR_RAMP)
        begin
            ref_dac_code <= ref_start;
            // Negated rise slew, halved per doubling of ramp time
            ramp_step <= (ref_start >> (ssr_pkg::RAMP_BASE_SHIFT
                + int'(ramp_shift_run))) + 16'h0001;
        end
        else if (state == SSR_RAMP && tick_us)
        begin
            if (ref_dac_code <= ramp_step)
            begin
                ref_dac_code <= 16'h0000;
            end
            else
            begin
                ref_dac_code <= ref_dac_code - ramp_step;
            end
        end
        else if (state == SSR_IDLE)
        begin
            ref_dac_code <= 16'h0000;
        end
    end

    assign ramp_active = (state == SSR_RAMP);

    // ****************************************************************
    // Power stage enable
    // ****************************************************************
    // Fall seen at the output is often shorter than the programmed ramp
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            switching_en <= 1'b0;
        end
        else if (state == SSR_OFF)
        begin
            switching_en <= 1'b0;
        end
        else if (state == SSR_RAMP && vout_low)
        begin
            switching_en <= 1'b0;
        end
        else if (state == SSR_IDLE || state == SSR_DELAY)
        begin
            switching_en <= 1'b1;
        end
    end

endmodule : ssr_soft_stop

// *** dv/ssr_soft_stop_chk.sv ***
// Checker for the soft-stop timing register block, bound to its top.
// Assumes a synchronous active-high reset on ref_clk.
`timescale 1ns/1ns
module ssr_soft_stop_chk #(
    parameter int US_CYCLES = ssr_pkg::US_CYCLES,
    parameter int HALF_MS_US = ssr_pkg::HALF_MS_US
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_hit,
    input wire logic resp_valid,
    input wire logic resp_nack,
    input wire logic [15:0] resp_rdata,
    input wire logic cml_fault_set,
    input wire logic invalid_data_set,
    input wire logic nvm_restore,
    input wire logic vout_low_pin,
    input wire logic switching_en,
    input wire logic ramp_active
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ****************
    // Command answers
    // ****************
    resp_on_time_a: assert property (
        cmd_hit |=> resp_valid) else $error("answer missing after hit");
    no_stray_resp_a: assert property (
        !cmd_hit |=> !resp_valid) else $error("answer without a hit");
    fault_pair_a: assert property (
        cml_fault_set == resp_nack && invalid_data_set == resp_nack)
        else $error("fault flags differ from refusal");
    bad_delay_nack_a: assert property (
        cmd_hit && cmd_write && cmd_code == 8'h64 && !nvm_restore
        && cmd_wdata[15:3] != 13'h1F00 |=> resp_nack)
        else $error("bad delay write not refused");
    bad_ramp_nack_a: assert property (
        cmd_hit && cmd_write && cmd_code == 8'h65 && !nvm_restore
        && cmd_wdata[15:4] != 12'hF80 |=> resp_nack)
        else $error("bad ramp write not refused");
    good_write_ack_a: assert property (
        cmd_hit && cmd_write && ((cmd_code == 8'h64
        && cmd_wdata[15:3] == 13'h1F00) || (cmd_code == 8'h65
        && cmd_wdata[15:4] == 12'hF80)) |=> resp_valid && !resp_nack)
        else $error("good write refused");
    delay_format_a: assert property (
        cmd_hit && !cmd_write && cmd_code == 8'h64
        |=> resp_rdata[15:3] == 13'h1F00)
        else $error("delay read fixed bits wrong");
    ramp_format_a: assert property (
        cmd_hit && !cmd_write && cmd_code == 8'h65
        |=> resp_rdata[15:4] == 12'hF80)
        else $error("ramp read fixed bits wrong");
    delay_readback_a: assert property (
        (cmd_hit && cmd_write && cmd_code == 8'h64 && !nvm_restore
        && cmd_wdata[15:3] == 13'h1F00) ##1 !nvm_restore
        ##1 (cmd_hit && !cmd_write && cmd_code == 8'h64 && !nvm_restore)
        |=> resp_rdata[2:0] == $past(cmd_wdata[2:0], 3))
        else $error("delay mantissa not read back");
    // ****************
    // Stop sequence
    // ****************
    discharge_stop_a: assert property (
        (ramp_active && vout_low_pin) [*7] |-> !switching_en)
        else $error("switching kept after discharge");
endmodule : ssr_soft_stop_chk

bind ssr_soft_stop ssr_soft_stop_chk #(
    .US_CYCLES(US_CYCLES),
    .HALF_MS_US(HALF_MS_US)
) chk (
    .ref_clk(ref_clk), .rst(rst), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_hit(cmd_hit),
    .resp_valid(resp_valid), .resp_nack(resp_nack),
    .resp_rdata(resp_rdata), .cml_fault_set(cml_fault_set),
    .invalid_data_set(invalid_data_set), .nvm_restore(nvm_restore),
    .vout_low_pin(vout_low_pin), .switching_en(switching_en),
    .ramp_active(ramp_active)
);

// *** dv/ssr_host_model.sv ***
// Host model: word reads and writes on the command port.
// Assumes one transfer at a time, called from the testbench.
`timescale 1ns/1ns
module ssr_host_model (
    input wire logic ref_clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic resp_valid,
    input wire logic resp_nack,
    input wire logic [15:0] resp_rdata
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // Code and data lines are inverted on release so stale values cannot match
    task automatic xfer(input logic w, input logic [7:0] code,
        input logic [15:0] d, output logic v, output logic n,
        output logic [15:0] r);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = code;
        cmd_wdata = d;
        @(posedge ref_clk);
        #1;
        v = resp_valid;
        n = resp_nack;
        r = resp_rdata;
        cmd_valid = 1'b0;
        cmd_code = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
    endtask : xfer
endmodule : ssr_host_model

// *** dv/tb_top.sv ***
// Testbench: register access, refused writes, restore and stop timing.
// Assumes shortened tick parameters; expectations scale with them.
`timescale 1ns/1ns
module tb_top;
    localparam int US = 4;
    localparam int HALF = 5;
    logic ref_clk, rst, cmd_valid, cmd_write, cmd_hit, resp_valid, v, n;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, resp_rdata, ref_dac_code, r;
    logic resp_nack, cml_fault_set, invalid_data_set, nvm_restore;
    logic stop_req, vout_low_pin, switching_en, ramp_active;
    logic [1:0] nvm_delay_sel, nvm_ramp_sel;
    logic [4:0] boot_voltage_level;
    int errors, checks;
    logic [2:0] dcan [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    logic [3:0] rcan [4] = '{4'h0, 4'h2, 4'h4, 4'h8};
    logic [15:0] bad64 [3] = '{16'hF80D, 16'h7805, 16'hFC05};
    logic [15:0] bad65 [3] = '{16'hF819, 16'h7809, 16'hFC09};

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    ssr_soft_stop #(.US_CYCLES(US), .HALF_MS_US(HALF)) uut (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_hit(cmd_hit), .resp_valid(resp_valid), .resp_nack(resp_nack),
        .resp_rdata(resp_rdata), .cml_fault_set(cml_fault_set),
        .invalid_data_set(invalid_data_set), .nvm_restore(nvm_restore),
        .nvm_delay_sel(nvm_delay_sel), .nvm_ramp_sel(nvm_ramp_sel),
        .stop_req(stop_req), .boot_voltage_level(boot_voltage_level),
        .vout_low_pin(vout_low_pin), .switching_en(switching_en),
        .ramp_active(ramp_active), .ref_dac_code(ref_dac_code));
    ssr_host_model host (
        .ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .resp_valid(resp_valid), .resp_nack(resp_nack),
        .resp_rdata(resp_rdata));

    // ****************
    // Shared tasks
    // ****************
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic timeout();
        errors++;
        $display("mismatch wait expected done seen timeout");
        conclude();
    endtask : timeout

    task automatic wr(input logic [7:0] c, input logic [15:0] d,
        input logic bad);
        host.xfer(1'b1, c, d, v, n, r);
        check("write ack", 16'h1, {15'h0, v});
        check("write nack", {15'h0, bad}, {15'h0, n});
        check("cml flag", {15'h0, bad}, {15'h0, cml_fault_set});
        check("ivd flag", {15'h0, bad}, {15'h0, invalid_data_set});
    endtask : wr

    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        host.xfer(1'b0, c, 16'h0000, v, n, r);
        check("read answer", 16'h2, {14'h0, v, n});
        check("read data", exp, r);
    endtask : rd

    // Settings are written first so each stop uses fresh values
    task automatic stop_run(input logic [2:0] dm, input logic [3:0] rm,
        input logic [4:0] lvl, input int halves, input int shift,
        input logic drop);
        int cnt;
        int start;
        int step;
        int lim;
        int dly;
        start = (int'(lvl) + 1) << 7;
        step = (start >> (9 + shift)) + 1;
        lim = ((start + step - 1) / step) * US;
        dly = 2 + halves * HALF * US;
        wr(8'h64, {13'h1F00, dm}, 1'b0);
        wr(8'h65, {12'hF80, rm}, 1'b0);
        boot_voltage_level = lvl;
        stop_req = 1'b1;
        cnt = 0;
        while (ramp_active !== 1'b1)
        begin
            @(posedge ref_clk);
            #1;
            cnt++;
            if (cnt > 200)
                timeout();
        end
        check("delay", 16'h1, 16'(cnt >= dly && cnt <= dly + 8));
        check("ramp start", 16'(start), ref_dac_code);
        cnt = 0;
        while (ramp_active === 1'b1)
        begin
            @(posedge ref_clk);
            #1;
            cnt++;
            if (cnt == 10)
                vout_low_pin = drop;
            if (cnt == 20 && drop)
                check("switching", 16'h0, {15'h0, switching_en});
            if (cnt > lim + 50)
                timeout();
        end
        if (!drop)
            check("ramp", 16'h1, 16'(cnt >= lim - 8 && cnt <= lim + 8));
        vout_low_pin = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check("stopped", 16'h0, {15'h0, switching_en});
        check("ref zero", 16'h0, ref_dac_code);
        stop_req = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check("restarted", 16'h1, {15'h0, switching_en});
    endtask : stop_run

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        errors = 0;
        checks = 0;
        rst = 1'b1;
        nvm_restore = 1'b0;
        nvm_delay_sel = 2'h0;
        nvm_ramp_sel = 2'h0;
        stop_req = 1'b0;
        boot_voltage_level = 5'h00;
        vout_low_pin = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        rd(8'h64, 16'hF800);
        rd(8'h65, 16'hF800);
        for (int i = 0; i < 16; i++)
        begin
            wr(8'h65, 16'hF800 | 16'(i), 1'b0);
            rd(8'h65, 16'hF800 | 16'(i));
            wr(8'h64, 16'hF800 | 16'(i % 8), 1'b0);
            rd(8'h64, 16'hF800 | 16'(i % 8));
        end
        wr(8'h64, 16'hF805, 1'b0);
        wr(8'h65, 16'hF809, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h64, bad64[i], 1'b1);
            rd(8'h64, 16'hF805);
            wr(8'h65, bad65[i], 1'b1);
            rd(8'h65, 16'hF809);
        end
        host.xfer(1'b0, 8'h66, 16'h0000, v, n, r);
        check("unmapped", 16'h0, {15'h0, v});
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            #1;
            nvm_restore = 1'b1;
            nvm_delay_sel = 2'(i);
            nvm_ramp_sel = 2'(3 - i);
            @(posedge ref_clk);
            #1;
            nvm_restore = 1'b0;
            rd(8'h64, {13'h1F00, dcan[i]});
            rd(8'h65, {12'hF80, rcan[3 - i]});
        end
        stop_run(3'h0, 4'h1, 5'h00, 0, 0, 1'b0);
        stop_run(3'h2, 4'h3, 5'h1F, 2, 1, 1'b0);
        stop_run(3'h3, 4'h7, 5'h1F, 3, 2, 1'b0);
        stop_run(3'h7, 4'hF, 5'h1F, 4, 3, 1'b0);
        stop_run(3'h1, 4'h0, 5'h1F, 2, 0, 1'b1);
        conclude();
    end
endmodule : tb_top
